// [design/dspdec_pkg.sv]
// Constants for the instruction decoder and its register map
package dspdec_pkg;
  // Register byte offsets
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_PC     = 8'h04;
  localparam logic [7:0] ADR_COND   = 8'h08;
  localparam logic [7:0] ADR_ACC    = 8'h0C;
  localparam logic [7:0] ADR_STATUS = 8'h10;
  localparam logic [7:0] ADR_INSTR  = 8'h14;
  localparam logic [7:0] ADR_OPER   = 8'h18;
  localparam logic [7:0] ADR_COUNT  = 8'h1C;
  // Field positions
  localparam int CTRL_RUN_BIT  = 0;
  localparam int COND_TC_BIT   = 4;
  localparam int COND_AUX_BIT  = 5;
  localparam int ST_BUSY_BIT   = 8;
  localparam int ST_TAKEN_BIT  = 9;
  localparam int CF_Z          = 3;
  localparam int CF_L          = 2;
  localparam int CF_V          = 1;
  localparam int CF_C          = 0;
  // Reset values
  localparam logic [15:0] PC_RESET   = 16'h0000;
  localparam logic [5:0]  COND_RESET = 6'h00;
  // Opcode patterns
  localparam logic [15:0] PAT_ABS       = 16'hBE00;
  localparam logic [15:0] PAT_PRODUCT_ACCUMULATE_OP      = 16'hBE04;
  localparam logic [15:0] PAT_BRANCH_TO_ACC_OP      = 16'hBE20;
  localparam logic [15:0] PAT_AND16     = 16'hBE81;
  localparam logic [3:0]  PFX_ADD_SHIFT = 4'h2;
  localparam logic [7:0]  PFX_ADD_HIGH  = 8'h61;
  localparam logic [7:0]  PFX_ADD_SHORT = 8'hB8;
  localparam logic [11:0] PFX_ADD_LONG  = 12'hBF9;
  localparam logic [7:0]  PFX_ADD_WITH_CARRY_OP      = 8'h60;
  localparam logic [7:0]  PFX_ADD_NO_SIGN_EXTEND_OP      = 8'h62;
  localparam logic [7:0]  PFX_ADD_SHIFT_BY_TEMP_OP      = 8'h63;
  localparam logic [7:0]  PFX_AUX_REG_ADD_IMM_OP      = 8'h78;
  localparam logic [11:0] PFX_AND_LONG  = 12'hBFB;
  localparam logic [7:0]  PFX_BRANCH_AUX_NONZERO_OP      = 8'h7B;
  localparam logic [5:0]  PFX_CONDITIONAL_BRANCH_OP      = 6'h38;
  // Selector codes
  localparam logic [1:0] SEL_PIN_LOW  = 2'h0;
  localparam logic [1:0] SEL_TC_SET   = 2'h1;
  localparam logic [1:0] SEL_TC_CLEAR = 2'h2;
  localparam logic [1:0] SEL_NONE     = 2'h3;
  // Cycle counts
  localparam logic [2:0] CYC_ONE        = 3'h1;
  localparam logic [2:0] CYC_TWO        = 3'h2;
  localparam logic [2:0] CYC_TAKEN      = 3'h4;
  localparam logic [2:0] CYC_PIN_NOT    = 3'h3;
  // Decoded operation codes
  localparam logic [4:0] OP_UNKNOWN   = 5'h00;
  localparam logic [4:0] OP_ABS       = 5'h01;
  localparam logic [4:0] OP_ADD_SHIFT = 5'h02;
  localparam logic [4:0] OP_ADD_HIGH  = 5'h03;
  localparam logic [4:0] OP_ADD_SHORT = 5'h04;
  localparam logic [4:0] OP_ADD_LONG  = 5'h05;
  localparam logic [4:0] OP_ADD_WITH_CARRY_OP      = 5'h06;
  localparam logic [4:0] OP_ADD_NO_SIGN_EXTEND_OP      = 5'h07;
  localparam logic [4:0] OP_ADD_SHIFT_BY_TEMP_OP      = 5'h08;
  localparam logic [4:0] OP_AUX_REG_ADD_IMM_OP      = 5'h09;
  localparam logic [4:0] OP_AND16     = 5'h0A;
  localparam logic [4:0] OP_AND_LONG  = 5'h0B;
  localparam logic [4:0] OP_PRODUCT_ACCUMULATE_OP      = 5'h0C;
  localparam logic [4:0] OP_BRANCH_TO_ACC_OP      = 5'h0D;
  localparam logic [4:0] OP_BRANCH_AUX_NONZERO_OP      = 5'h0E;
  localparam logic [4:0] OP_CONDITIONAL_BRANCH_OP      = 5'h0F;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_FETCH  = 4'b0010,
    ST_FETCH2 = 4'b0100,
    ST_EXEC   = 4'b1000
  } dspdec_state_t;
endpackage

// [design/dspdec_top.sv]
// Instruction decoder with condition evaluation and fetch sequencer
//
// The register addresses and register access over Wishbone are this design's own decisions.
`timescale 1ns/100ps
module dspdec_top
  import dspdec_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_ack_o,
  output logic      [31:0] wb_dat_o,
  // Program memory
  output logic             pm_stb,
  output logic      [15:0] pm_addr,
  input  wire logic        pm_ack,
  input  wire logic [15:0] pm_data,
  // External input pin, active low
  input  wire logic        ext_input_n,
  // Decode results
  output logic             dec_valid,
  output logic      [4:0]  dec_op,
  output logic             dec_taken,
  output logic      [15:0] dec_operand,
  output logic      [3:0]  shift_amount_field,
  output logic      [7:0]  immediate_constant_field
);

  dspdec_state_t state_reg;
  dspdec_state_t state_next;

  logic        run_reg;
  logic [15:0] pc_reg;
  logic [3:0]  acc_condition_field;
  logic        test_control_flag;
  logic        aux_nonzero_reg;
  logic [15:0] acc_reg;
  logic [15:0] instr_reg;
  logic [15:0] oper_reg;
  logic [31:0] count_reg;
  logic [2:0]  cyc_reg;
  logic        taken_reg;
  logic        wb_req;
  logic        wb_wr;

  // Decode of the word in hand
  logic [15:0] cur;
  logic [4:0]  op;
  logic        two_words;
  logic        is_branch;
  logic [2:0]  cyc_taken;
  logic [2:0]  cyc_not;
  logic        taken;
  logic [1:0]  branch_cond_selector;
  logic [3:0]  cond_mask;
  logic [3:0]  cond_state;
  logic [3:0]  cond_hit;
  logic        acc_condition_field_ok;
  logic        sel_ok;
  logic        input_pin_low_cond;
  logic        test_control_clear_cond;
  logic [15:0] target;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr  = wb_req & wb_we_i;

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] dat,
    input logic [3:0]  sel
  );
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (dat & m);
  endfunction

  always_comb begin
    cur = (state_reg == ST_FETCH) ? pm_data : instr_reg;
  end

  always_comb begin
    op        = OP_UNKNOWN;
    two_words = 1'b0;
    is_branch = 1'b0;
    cyc_taken = CYC_ONE;
    cyc_not   = CYC_ONE;
    if (cur == PAT_ABS) begin
      op = OP_ABS;
    end else if (cur == PAT_PRODUCT_ACCUMULATE_OP) begin
      op = OP_PRODUCT_ACCUMULATE_OP;
    end else if (cur == PAT_BRANCH_TO_ACC_OP) begin
      op        = OP_BRANCH_TO_ACC_OP;
      is_branch = 1'b1;
      cyc_taken = CYC_TAKEN;
      cyc_not   = CYC_TAKEN;
    end else if (cur == PAT_AND16) begin
      op        = OP_AND16;
      two_words = 1'b1;
      cyc_taken = CYC_TWO;
      cyc_not   = CYC_TWO;
    end else if (cur[15:4] == PFX_AND_LONG) begin
      op        = OP_AND_LONG;
      two_words = 1'b1;
      cyc_taken = CYC_TWO;
      cyc_not   = CYC_TWO;
    end else if (cur[15:4] == PFX_ADD_LONG) begin
      op        = OP_ADD_LONG;
      two_words = 1'b1;
      cyc_taken = CYC_TWO;
      cyc_not   = CYC_TWO;
    end else if (cur[15:12] == PFX_ADD_SHIFT) begin
      op = OP_ADD_SHIFT;
    end else if (cur[15:8] == PFX_ADD_HIGH) begin
      op = OP_ADD_HIGH;
    end else if (cur[15:8] == PFX_ADD_SHORT) begin
      op = OP_ADD_SHORT;
    end else if (cur[15:8] == PFX_ADD_WITH_CARRY_OP) begin
      op = OP_ADD_WITH_CARRY_OP;
    end else if (cur[15:8] == PFX_ADD_NO_SIGN_EXTEND_OP) begin
      op = OP_ADD_NO_SIGN_EXTEND_OP;
    end else if (cur[15:8] == PFX_ADD_SHIFT_BY_TEMP_OP) begin
      op = OP_ADD_SHIFT_BY_TEMP_OP;
    end else if (cur[15:8] == PFX_AUX_REG_ADD_IMM_OP) begin
      op = OP_AUX_REG_ADD_IMM_OP;
    end else if (cur[15:8] == PFX_BRANCH_AUX_NONZERO_OP) begin
      op        = OP_BRANCH_AUX_NONZERO_OP;
      two_words = 1'b1;
      is_branch = 1'b1;
      cyc_taken = CYC_TAKEN;
      cyc_not   = CYC_TWO;
    end else if (cur[15:10] == PFX_CONDITIONAL_BRANCH_OP) begin
      op        = OP_CONDITIONAL_BRANCH_OP;
      two_words = 1'b1;
      is_branch = 1'b1;
      cyc_taken = CYC_TAKEN;
      cyc_not   = (cur[9:8] == SEL_PIN_LOW) ? CYC_PIN_NOT : CYC_TWO;
    end
  end

  // Condition evaluation for the conditional branch group
  always_comb begin
    branch_cond_selector    = cur[9:8];
    cond_mask               = cur[3:0];
    cond_state              = cur[7:4];
    input_pin_low_cond      = ~ext_input_n;
    test_control_clear_cond = ~test_control_flag;
    // Masked condition bits that match their required state
    cond_hit = cond_mask & ~(cond_state ^ acc_condition_field);
    acc_condition_field_ok  = (cond_mask == 4'h0) | (|cond_hit);
    case (branch_cond_selector)
      SEL_PIN_LOW:  sel_ok = input_pin_low_cond;
      SEL_TC_SET:   sel_ok = test_control_flag;
      SEL_TC_CLEAR: sel_ok = test_control_clear_cond;
      default:      sel_ok = 1'b1;
    endcase
  end

  always_comb begin
    case (op)
      OP_BRANCH_TO_ACC_OP: taken = 1'b1;
      OP_BRANCH_AUX_NONZERO_OP: taken = aux_nonzero_reg;
      OP_CONDITIONAL_BRANCH_OP: taken = sel_ok & acc_condition_field_ok;
      default: taken = 1'b0;
    endcase
    target = (op == OP_BRANCH_TO_ACC_OP) ? acc_reg : oper_reg;
  end

  // Sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (run_reg) begin
          state_next = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (pm_ack) begin
          state_next = two_words ? ST_FETCH2 : ST_EXEC;
        end
      end
      ST_FETCH2: begin
        if (pm_ack) begin
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (cyc_reg == CYC_ONE) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Program memory strobe and address
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pm_stb  <= 1'b0;
      pm_addr <= PC_RESET;
    end else begin
      case (state_next)
        ST_FETCH: begin
          pm_stb  <= ~(state_reg == ST_FETCH && pm_ack);
          pm_addr <= pc_reg;
        end
        ST_FETCH2: begin
          pm_stb  <= ~(state_reg == ST_FETCH2 && pm_ack);
          pm_addr <= pc_reg + 16'h0001;
        end
        default: pm_stb <= 1'b0;
      endcase
    end
  end

  // Instruction and operand words
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      instr_reg <= 16'h0000;
      oper_reg  <= 16'h0000;
    end else begin
      if (state_reg == ST_FETCH && pm_ack) begin
        instr_reg <= pm_data;
      end
      if (state_reg == ST_FETCH2 && pm_ack) begin
        oper_reg <= pm_data;
      end
    end
  end

  // Cycle count and branch decision taken at entry to execution
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cyc_reg   <= CYC_ONE;
      taken_reg <= 1'b0;
    end else if (state_next == ST_EXEC && state_reg != ST_EXEC) begin
      taken_reg <= taken;
      cyc_reg   <= taken ? cyc_taken : cyc_not;
    end else if (state_reg == ST_EXEC) begin
      cyc_reg <= cyc_reg - CYC_ONE;
    end
  end

  // Software registers and program counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run_reg             <= 1'b0;
      pc_reg              <= PC_RESET;
      acc_condition_field <= COND_RESET[3:0];
      test_control_flag   <= COND_RESET[COND_TC_BIT];
      aux_nonzero_reg     <= COND_RESET[COND_AUX_BIT];
      acc_reg             <= 16'h0000;
    end else begin
      if (wb_wr && wb_adr_i == ADR_CTRL && wb_sel_i[0]) begin
        run_reg <= wb_dat_i[CTRL_RUN_BIT];
      end
      if (wb_wr && wb_adr_i == ADR_COND && wb_sel_i[0]) begin
        acc_condition_field <= wb_dat_i[3:0];
        test_control_flag   <= wb_dat_i[COND_TC_BIT];
        aux_nonzero_reg     <= wb_dat_i[COND_AUX_BIT];
      end
      if (wb_wr && wb_adr_i == ADR_ACC) begin
        acc_reg <= 16'(merge({16'h0000, acc_reg}, wb_dat_i, wb_sel_i));
      end
      // Retirement moves the counter past the instruction or to the target
      if (state_reg == ST_EXEC && cyc_reg == CYC_ONE) begin
        if (taken_reg) begin
          pc_reg <= target;
        end else if (two_words) begin
          pc_reg <= pc_reg + 16'h0002;
        end else begin
          pc_reg <= pc_reg + 16'h0001;
        end
      end else if (wb_wr && wb_adr_i == ADR_PC) begin
        pc_reg <= 16'(merge({16'h0000, pc_reg}, wb_dat_i, wb_sel_i));
      end
    end
  end

  // Retired instruction count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_reg <= 32'h0000_0000;
    end else if (state_reg == ST_EXEC && cyc_reg == CYC_ONE) begin
      count_reg <= count_reg + 32'h0000_0001;
    end else if (wb_wr && wb_adr_i == ADR_COUNT) begin
      count_reg <= merge(count_reg, wb_dat_i, wb_sel_i);
    end
  end

  // Decode result outputs, loaded at retirement and held, with dec_valid pulsed for one cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dec_valid                <= 1'b0;
      dec_op                   <= OP_UNKNOWN;
      dec_taken                <= 1'b0;
      dec_operand              <= 16'h0000;
      shift_amount_field       <= 4'h0;
      immediate_constant_field <= 8'h00;
    end else begin
      dec_valid <= state_reg == ST_EXEC && cyc_reg == CYC_ONE;
      if (state_reg == ST_EXEC && cyc_reg == CYC_ONE) begin
        dec_op    <= op;
        dec_taken <= taken_reg;
        if (op == OP_BRANCH_TO_ACC_OP) begin
          dec_operand <= acc_reg;
        end else if (two_words) begin
          dec_operand <= oper_reg;
        end else begin
          dec_operand <= {8'h00, cur[7:0]};
        end
        if (op == OP_ADD_SHIFT) begin
          shift_amount_field <= cur[11:8];
        end else if (op == OP_AND16) begin
          shift_amount_field <= 4'h0;
        end else begin
          shift_amount_field <= cur[3:0];
        end
        immediate_constant_field <= cur[7:0];
      end
    end
  end

  // Bus answer one cycle after the request, dropped the cycle after
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          ADR_CTRL:   wb_dat_o <= {31'h0, run_reg};
          ADR_PC:     wb_dat_o <= {16'h0000, pc_reg};
          ADR_COND:   wb_dat_o <= {26'h0, aux_nonzero_reg, test_control_flag,
                                   acc_condition_field};
          ADR_ACC:    wb_dat_o <= {16'h0000, acc_reg};
          ADR_STATUS: wb_dat_o <= {22'h0, dec_taken, state_reg != ST_IDLE,
                                   3'h0, dec_op};
          ADR_INSTR:  wb_dat_o <= {16'h0000, instr_reg};
          ADR_OPER:   wb_dat_o <= {16'h0000, oper_reg};
          ADR_COUNT:  wb_dat_o <= count_reg;
          default:    wb_dat_o <= 32'h0000_0000;
        endcase
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

endmodule

// [dv/dspdec_monitor.sv]
// Checker for handshakes and decode results of the decoder
`timescale 1ns/100ps
module dspdec_monitor
  import dspdec_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // Program memory
  input wire logic        pm_stb,
  input wire logic [15:0] pm_addr,
  input wire logic        pm_ack,
  input wire logic [15:0] pm_data,
  // Decode results
  input wire logic        dec_valid,
  input wire logic [4:0]  dec_op,
  input wire logic        dec_taken
);
  logic [15:0] word_reg;
  logic [15:0] addr_reg;
  logic        ret_reg;
  // Opcode word is the first fetch after a retirement
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      word_reg <= 16'h0;
      addr_reg <= 16'h0;
      ret_reg  <= 1'b1;
    end else if (pm_stb && pm_ack) begin
      addr_reg <= pm_addr;
      ret_reg  <= 1'b0;
      if (ret_reg)
        word_reg <= pm_data;
    end else if (dec_valid) begin
      ret_reg <= 1'b1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_wb_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ack_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
  a_wb_ack_once: assert property (s_wb_req |=> s_ack_pulse)
    else $error("bus ack not a single pulse");
  a_wb_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_pm_hold: assert property (pm_stb && !pm_ack |=> pm_stb && $stable(pm_addr))
    else $error("fetch request not held");
  // After the operand fetch the strobe drops, and the operand comes from the word after the opcode
  a_pm_release: assert property (pm_stb && pm_ack && !ret_reg |=> !pm_stb)
    else $error("fetch request not dropped");
  a_second_word: assert property (pm_stb && pm_ack && !ret_reg |->
    pm_addr == addr_reg + 16'h1)
    else $error("second word from wrong place");
  a_op_held: assert property (!dec_valid |-> $stable(dec_op) && $stable(dec_taken))
    else $error("result changed without retirement");
  a_abs_decode: assert property (dec_valid && word_reg == PAT_ABS |-> dec_op == OP_ABS)
    else $error("absolute value word misdecoded");
  a_acc_branch: assert property (dec_valid && word_reg == PAT_BRANCH_TO_ACC_OP |-> dec_taken)
    else $error("branch to accumulator not taken");
  a_cond_decode: assert property (dec_valid && word_reg[15:10] == PFX_CONDITIONAL_BRANCH_OP |->
    dec_op == OP_CONDITIONAL_BRANCH_OP)
    else $error("conditional branch misdecoded");
  a_plain_untaken: assert property (dec_valid && dec_op < OP_BRANCH_TO_ACC_OP |-> !dec_taken)
    else $error("non-branch marked taken");
endmodule
bind dspdec_top dspdec_monitor MON (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .pm_stb(pm_stb),
  .pm_addr(pm_addr), .pm_ack(pm_ack), .pm_data(pm_data), .dec_valid(dec_valid),
  .dec_op(dec_op), .dec_taken(dec_taken));

// [dv/dspdec_pmem.sv]
// Program memory model answering fetches after a selectable wait
`timescale 1ns/100ps
module dspdec_pmem (
  // Clock
  input  wire logic        clk,
  // Fetch port
  input  wire logic        pm_stb,
  input  wire logic [15:0] pm_addr,
  output logic             pm_ack,
  output logic      [15:0] pm_data,
  // Answer delay in cycles
  input  wire logic [1:0]  wait_cycles
);
  logic [15:0] mem [64];
  logic [1:0]  cnt_reg = 2'h0;
  initial pm_ack = 1'b0;
  initial pm_data = 16'h0;
  always @(posedge clk) begin
    if (pm_stb === 1'b1 && !pm_ack && cnt_reg == wait_cycles) begin
      pm_ack  <= 1'b1;
      pm_data <= mem[pm_addr[5:0]];
      cnt_reg <= 2'h0;
    end else begin
      pm_ack  <= 1'b0;
      // Data inverts every cycle without an ack, so a released bus does not hold the last word
      pm_data <= ~pm_data;
      if (pm_stb === 1'b1 && !pm_ack)
        cnt_reg <= cnt_reg + 2'h1;
    end
  end
endmodule

// [dv/tb_dspdec_top.sv]
// Self-checking testbench for the instruction decoder
`timescale 1ns/100ps
module tb_dspdec_top;
  import dspdec_pkg::*;
  typedef struct packed {
    logic [4:0]  op;
    logic        taken;
    logic [15:0] opd;
    logic [2:0]  n;
    logic [3:0]  sh;
    logic        chk_sh;
    logic [7:0]  imm;
  } dspdec_exp_t;
  localparam int NI = 24;
  localparam logic [15:0] PW [NI] = '{16'hBE00, 16'h2A35, 16'h6112, 16'hB87F, 16'hBF93,
    16'h6034, 16'h6256, 16'h6378, 16'h78FF, 16'hBE81, 16'hBFB4, 16'hBE04, 16'hBE20,
    16'h7B80, 16'hE100, 16'hE200, 16'hE38C, 16'hE3CC, 16'hE344, 16'hE302, 16'hE311,
    16'hE000, 16'h4000, 16'hE300};
  localparam logic [4:0] PO [NI] = '{OP_ABS, OP_ADD_SHIFT, OP_ADD_HIGH, OP_ADD_SHORT,
    OP_ADD_LONG, OP_ADD_WITH_CARRY_OP, OP_ADD_NO_SIGN_EXTEND_OP, OP_ADD_SHIFT_BY_TEMP_OP, OP_AUX_REG_ADD_IMM_OP, OP_AND16, OP_AND_LONG, OP_PRODUCT_ACCUMULATE_OP,
    OP_BRANCH_TO_ACC_OP, OP_BRANCH_AUX_NONZERO_OP, OP_CONDITIONAL_BRANCH_OP, OP_CONDITIONAL_BRANCH_OP, OP_CONDITIONAL_BRANCH_OP, OP_CONDITIONAL_BRANCH_OP, OP_CONDITIONAL_BRANCH_OP, OP_CONDITIONAL_BRANCH_OP, OP_CONDITIONAL_BRANCH_OP,
    OP_CONDITIONAL_BRANCH_OP, OP_UNKNOWN, OP_CONDITIONAL_BRANCH_OP};
  // Kinds: 0 one word, 1 two words, 2 conditional, 3 to acc, 4 aux nonzero
  localparam logic [2:0] PK [NI] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0,
    3'h1, 3'h1, 3'h0, 3'h3, 3'h4, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h0, 3'h2};
  logic        clk;
  logic        rst_n;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic        wb_ack_o;
  logic [31:0] wb_dat_o;
  logic        pm_stb;
  logic [15:0] pm_addr;
  logic        pm_ack;
  logic [15:0] pm_data;
  logic        ext_input_n;
  logic        dec_valid;
  logic [4:0]  dec_op;
  logic        dec_taken;
  logic [15:0] dec_operand;
  logic [3:0]  shift_amount_field;
  logic [7:0]  imm_field;
  logic [1:0]  wait_cycles;
  logic [15:0] sec [NI];
  logic [15:0] acc;
  logic [15:0] seed;
  logic [31:0] rd;
  dspdec_exp_t exp_q [$];
  dspdec_exp_t got;
  int          num_errors;
  int          checked;
  int          cyc_cnt;
  int          ack_cyc;

  dspdec_top DUT (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .pm_stb(pm_stb), .pm_addr(pm_addr),
    .pm_ack(pm_ack), .pm_data(pm_data), .ext_input_n(ext_input_n), .dec_valid(dec_valid),
    .dec_op(dec_op), .dec_taken(dec_taken), .dec_operand(dec_operand),
    .shift_amount_field(shift_amount_field), .immediate_constant_field(imm_field));
  dspdec_pmem PM (.clk(clk), .pm_stb(pm_stb), .pm_addr(pm_addr), .pm_ack(pm_ack),
    .pm_data(pm_data), .wait_cycles(wait_cycles));

  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic bc_taken(logic [15:0] w, logic [5:0] c, logic pin_n);
    logic mok;
    logic sok;
    mok = (w[3:0] == 4'h0) || |(w[3:0] & ~(w[7:4] ^ c[3:0]));
    case (w[9:8])
      2'h0: sok = !pin_n;
      2'h1: sok = c[4];
      2'h2: sok = !c[4];
      default: sok = 1'b1;
    endcase
    return mok && sok;
  endfunction
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wb(logic we, logic [7:0] adr, logic [31:0] dat, logic [3:0] sel,
                    output logic [31:0] v);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    v = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rdchk(string name, logic [7:0] adr, logic [31:0] exp);
    logic [31:0] v;
    wb(1'b0, adr, 32'h0, 4'hF, v);
    check(name, v, exp);
  endtask
  task automatic load_prog();
    logic [15:0] pc;
    pc = 16'h0;
    for (int i = 0; i < NI; i++) begin
      PM.mem[pc[5:0]] = PW[i];
      if (PK[i] == 3'h3)
        acc = pc + 16'h1;
      if (PK[i] == 3'h1 || PK[i] == 3'h2 || PK[i] == 3'h4) begin
        sec[i] = (PK[i] == 3'h1) ? {pc[7:0], 8'hC3} : (i == NI - 1) ? 16'h0 : pc + 16'h2;
        PM.mem[pc[5:0] + 6'h1] = sec[i];
        pc = pc + 16'h2;
      end else begin
        pc = pc + 16'h1;
      end
    end
  endtask
  task automatic run_pass();
    logic [5:0]  c;
    logic [15:0] w;
    dspdec_exp_t e;
    seed = lfsr(seed);
    c = seed[5:0];
    ext_input_n <= seed[6];
    wait_cycles <= seed[8:7];
    wb(1'b1, ADR_PC, 32'h0, 4'hF, rd);
    wb(1'b1, ADR_COND, {26'h0, c}, 4'h1, rd);
    for (int i = 0; i < NI; i++) begin
      w = PW[i];
      e.op = PO[i];
      e.taken = (PK[i] == 3'h2) ? bc_taken(w, c, seed[6]) : (PK[i] == 3'h3) ? 1'b1
              : (PK[i] == 3'h4) ? c[5] : 1'b0;
      e.opd = (PK[i] == 3'h3) ? acc : (PK[i] == 3'h0) ? {8'h0, w[7:0]} : sec[i];
      e.n = (PK[i] == 3'h0) ? CYC_ONE : e.taken ? CYC_TAKEN
          : (w == 16'hE000) ? CYC_PIN_NOT : CYC_TWO;
      e.sh = (i == 1) ? w[11:8] : w[3:0];
      e.chk_sh = (i == 1 || i == 4 || i == 10);
      e.imm = w[7:0];
      exp_q.push_back(e);
    end
    wb(1'b1, ADR_CTRL, 32'h1, 4'h1, rd);
    while (exp_q.size() != 0)
      @(posedge clk);
    wb(1'b1, ADR_CTRL, 32'h0, 4'h1, rd);
    do wb(1'b0, ADR_STATUS, 32'h0, 4'hF, rd); while (rd[ST_BUSY_BIT] !== 1'b0);
  endtask

  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 30000) begin
      num_errors++;
      end_of_test();
    end
  end
  // Retirements past the end of a pass are not scored
  always @(posedge clk) begin
    if (pm_stb === 1'b1 && pm_ack === 1'b1)
      ack_cyc <= cyc_cnt;
    if (dec_valid === 1'b1 && exp_q.size() > 0) begin
      got = exp_q.pop_front();
      check("op", {27'h0, dec_op}, {27'h0, got.op});
      check("taken", {31'h0, dec_taken}, {31'h0, got.taken});
      check("operand", {16'h0, dec_operand}, {16'h0, got.opd});
      check("imm", {24'h0, imm_field}, {24'h0, got.imm});
      check("cycles", cyc_cnt - ack_cyc, got.n + 1);
      if (got.chk_sh)
        check("shift", {28'h0, shift_amount_field}, {28'h0, got.sh});
    end
  end
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    ext_input_n = 1'b1;
    wait_cycles = 2'h0;
    seed = 16'hEE17;
    num_errors = 0;
    checked = 0;
    cyc_cnt = 0;
    ack_cyc = 0;
    load_prog();
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rdchk("count", ADR_COUNT, 32'h0);
    rdchk("pc", ADR_PC, {16'h0, PC_RESET});
    rdchk("cond", ADR_COND, {26'h0, COND_RESET});
    rdchk("status", ADR_STATUS, 32'h0);
    wb(1'b1, 8'h20, 32'hFFFF_FFFF, 4'hF, rd);
    rdchk("unmapped", 8'h20, 32'h0);
    wb(1'b1, ADR_COUNT, 32'hFFFF_5678, 4'h3, rd);
    rdchk("count", ADR_COUNT, 32'h0000_5678);
    wb(1'b1, ADR_ACC, {16'h0, acc}, 4'hF, rd);
    rdchk("acc", ADR_ACC, {16'h0, acc});
    repeat (6) run_pass();
    end_of_test();
  end
endmodule
